// *** rtl/sar_adc_sequencer.v ***
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
// What this block does
// - Each conversion uses eight comparisons, MSB first, each fixing one bit.
// - Finished approximation is copied to the result register for its position.
// - Power-up bit enables charge pump; converter waits up to 100 us settling.
// - Four readable 8-bit result registers; done flag marks all four valid.
// - Result registers update only in cycles that are not a bus read's wait cycle.
// - Clock select: 1 picks internal RC clock, 0 the system clock, also for NVM pump.
// - Conversions run in sequences of four; done flag set after the fourth.
// - Sequence starts one cycle after a control write, with bits just written.
// - Low reference gives 00, high reference gives FF, no overflow indication.
// - Option bit 7 powers and enables the converter; clear disables it all.
// - Protected option bits writable once within 64 cycles of reset, or in special mode.
// - Sixteen channels: inputs 0-7, reserved, high ref, low ref, half ref, reserved.
// - Single channel, no scan: four conversions into results 1-4, then halt.
// - Multi channel, no scan: group of four converted once into results 1-4, halt.
// - Scan set: conversions continue, fifth overwrites result 1, round robin.
// - Control write during conversion aborts and restarts with the new settings.
// - Control bit 7 is read-only done flag, bit 6 reads zero, 5-0 read/write.
// - Every control write clears the done flag; it starts a sequence only while powered.
// - In scan mode done flag sets after first sequence; results keep updating.
// - Multi set: one register per channel; clear: one channel fills all four.
// - Channel bits binary; in multi mode the two low bits are ignored.
`include "sar_adc_sequencer_regs.vh"

module sar_adc_sequencer #(
  parameter SETTLE_CYCLES = `SETTLE_CYC
) (
  input wire mclk,
  input wire rst,
  input wire [9:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  input wire [3:0] avsByteEnable,
  output reg [31:0] avsReadData,
  output wire avsWaitRequest,
  output reg [1:0] avsResponse,
  input wire compOut,
  output reg [7:0] dacCode,
  output reg [3:0] muxChannel,
  output reg sampleGate,
  output wire chargePumpEn,
  output wire biasEn,
  output wire rcOscEn,
  output wire nvmPumpClkSel,
  output wire convBusy
);

  // Sequencer states
  localparam ST_IDLE = 2'd0;
  localparam ST_SETTLE = 2'd1;
  localparam ST_SAMPLE = 2'd2;
  localparam ST_CONVERT = 2'd3;

  // Registers
  reg [7:0] ctrl_ff;
  reg doneFlag_ff;
  reg [7:0] option_ff;
  reg protWritten_ff;
  reg [6:0] protCnt_ff;
  reg specialMode_ff;
  reg [7:0] result_ff [0:3];
  reg [1:0] state_ff;
  reg [1:0] convIdx_ff;
  reg [2:0] bitIdx_ff;
  reg [7:0] sar_ff;
  reg [3:0] sampleCnt_ff;
  reg [15:0] settleCnt_ff;
  reg startPend_ff;
  reg [7:0] rcDiv_ff;
  reg rcTick_ff;
  reg pendValid_ff;
  reg [7:0] pendData_ff;
  reg [1:0] pendIdx_ff;
  reg ack_ff;
  reg eTick_ff;

  // Nets
  wire wrEn;
  wire rdEn;
  wire ctrlWrite;
  wire stepTick;
  wire powered;
  wire [3:0] curChannel;
  wire [7:0] trialCode;
  wire settled;
  wire convStep;
  wire seqEnd;
  reg [31:0] nxt_readData;
  reg hit;

  // One wait state: request completes on the edge after it is first seen
  assign avsWaitRequest = (avsRead | avsWrite) & ~ack_ff;
  assign wrEn = avsWrite & ack_ff;
  assign rdEn = avsRead & ~ack_ff;
  assign ctrlWrite = wrEn & (avsAddress == `ADC_CTRL_ADDR) & avsByteEnable[0];

  assign powered = option_ff[`OPT_PWR_BIT];
  assign chargePumpEn = powered;
  assign biasEn = powered;
  assign rcOscEn = powered & option_ff[`OPT_CONV_CLOCK_SELECT_BIT];
  assign nvmPumpClkSel = option_ff[`OPT_CONV_CLOCK_SELECT_BIT];
  assign convBusy = (state_ff != ST_IDLE);

  // Step pacing: every second system clock (E tick), or the divided RC tick
  assign stepTick = option_ff[`OPT_CONV_CLOCK_SELECT_BIT] ? rcTick_ff : eTick_ff;

  // Multi mode keeps high two bits and walks the group
  assign curChannel = ctrl_ff[`CTRL_MULTI_CHANNEL_SELECT_BIT] ?
    {ctrl_ff[3:2], convIdx_ff} : ctrl_ff[3:0];
  assign trialCode = sar_ff | (8'h80 >> bitIdx_ff);
  assign settled = (settleCnt_ff == SETTLE_CYCLES[15:0]);
  assign convStep = (state_ff == ST_CONVERT) & stepTick;
  // Last step of the fourth conversion ends the sequence
  assign seqEnd = powered & ~startPend_ff & convStep & (bitIdx_ff == 3'd7) &
    (convIdx_ff == 2'd3);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avsRead | avsWrite) & ~ack_ff;
    end
  end

  // Internal RC clock stand-in derived from system clock
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rcDiv_ff <= 8'h00;
      rcTick_ff <= 1'b0;
    end else if (rcDiv_ff == `RC_DIV_HALF) begin
      rcDiv_ff <= 8'h00;
      rcTick_ff <= 1'b1;
    end else begin
      rcDiv_ff <= rcDiv_ff + 8'h01;
      rcTick_ff <= 1'b0;
    end
  end

  // E clock steps every second cycle so the DAC code settles before the compare
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      eTick_ff <= 1'b0;
    end else begin
      eTick_ff <= ~eTick_ff;
    end
  end

  // Control register and done flag
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= 8'h00;
      doneFlag_ff <= 1'b0;
      startPend_ff <= 1'b0;
    end else begin
      startPend_ff <= ctrlWrite;
      if (ctrlWrite) begin
        ctrl_ff <= avsWriteData[7:0] & `CTRL_WR_MASK;
        doneFlag_ff <= 1'b0;
      end else if (seqEnd) begin
        doneFlag_ff <= 1'b1;
      end
    end
  end

  // Option register with protected bits
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      option_ff <= `OPT_RESET;
      protWritten_ff <= 1'b0;
      protCnt_ff <= 7'd0;
      specialMode_ff <= 1'b0;
    end else begin
      if (protCnt_ff != `PROT_WINDOW_CYC) begin
        protCnt_ff <= protCnt_ff + 7'd1;
      end
      if (wrEn && avsAddress == `MODE_CFG_ADDR && avsByteEnable[0]) begin
        specialMode_ff <= avsWriteData[0];
      end
      if (wrEn && avsAddress == `SYS_OPT_ADDR && avsByteEnable[0]) begin
        option_ff[7:6] <= avsWriteData[7:6];
        if (specialMode_ff || (!protWritten_ff && protCnt_ff != `PROT_WINDOW_CYC)) begin
          option_ff[5:0] <= avsWriteData[5:0];
          protWritten_ff <= 1'b1;
        end
      end
    end
  end

  // Settling counter after power-up
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      settleCnt_ff <= 16'h0000;
    end else if (!powered) begin
      settleCnt_ff <= 16'h0000;
    end else if (settleCnt_ff != SETTLE_CYCLES[15:0]) begin
      settleCnt_ff <= settleCnt_ff + 16'h0001;
    end
  end

  // Conversion sequencer
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      convIdx_ff <= 2'd0;
      bitIdx_ff <= 3'd0;
      sar_ff <= 8'h00;
      sampleCnt_ff <= 4'h0;
      pendValid_ff <= 1'b0;
      pendData_ff <= 8'h00;
      pendIdx_ff <= 2'd0;
    end else begin
      if (pendValid_ff && !rdEn) begin
        pendValid_ff <= 1'b0;
      end
      if (!powered) begin
        state_ff <= ST_IDLE;
      end else if (startPend_ff) begin
        state_ff <= ST_SETTLE;
        convIdx_ff <= 2'd0;
        bitIdx_ff <= 3'd0;
        sar_ff <= 8'h00;
        sampleCnt_ff <= 4'h0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            state_ff <= ST_IDLE;
          end
          ST_SETTLE: begin
            if (settled) begin
              state_ff <= ST_SAMPLE;
            end
          end
          ST_SAMPLE: begin
            if (stepTick) begin
              if (sampleCnt_ff == `SAMPLE_STEPS) begin
                sampleCnt_ff <= 4'h0;
                state_ff <= ST_CONVERT;
              end else begin
                sampleCnt_ff <= sampleCnt_ff + 4'h1;
              end
            end
          end
          ST_CONVERT: begin
            if (stepTick) begin
              // Keep trial bit when input is at or above the trial level
              if (compOut) begin
                sar_ff <= trialCode;
              end
              if (bitIdx_ff == 3'd7) begin
                pendValid_ff <= 1'b1;
                pendData_ff <= compOut ? trialCode : sar_ff;
                pendIdx_ff <= convIdx_ff;
                bitIdx_ff <= 3'd0;
                sar_ff <= 8'h00;
                convIdx_ff <= convIdx_ff + 2'd1;
                if (convIdx_ff == 2'd3 && !ctrl_ff[`CTRL_SCAN_BIT]) begin
                  state_ff <= ST_IDLE;
                end else begin
                  state_ff <= ST_SAMPLE;
                end
              end else begin
                bitIdx_ff <= bitIdx_ff + 3'd1;
              end
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Result storage deferred past read cycles
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_ff[0] <= 8'h00;
      result_ff[1] <= 8'h00;
      result_ff[2] <= 8'h00;
      result_ff[3] <= 8'h00;
    end else if (pendValid_ff && !rdEn) begin
      result_ff[pendIdx_ff] <= pendData_ff;
    end
  end

  // Trial code to the capacitor DAC
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      dacCode <= 8'h00;
    end else begin
      dacCode <= (state_ff == ST_CONVERT) ? trialCode : 8'h00;
    end
  end

  // Multiplexer channel select
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      muxChannel <= 4'h0;
    end else begin
      muxChannel <= curChannel;
    end
  end

  // Sample gate on the input switch
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sampleGate <= 1'b0;
    end else begin
      sampleGate <= (state_ff == ST_SAMPLE);
    end
  end

  // Read mux
  always @* begin
    nxt_readData = 32'h00000000;
    hit = 1'b1;
    case (avsAddress)
      `ADC_CTRL_ADDR: nxt_readData = {24'h000000, doneFlag_ff, 1'b0, ctrl_ff[5:0]};
      `ADC_RES1_ADDR: nxt_readData = {24'h000000, result_ff[0]};
      `ADC_RES2_ADDR: nxt_readData = {24'h000000, result_ff[1]};
      `ADC_RES3_ADDR: nxt_readData = {24'h000000, result_ff[2]};
      `ADC_RES4_ADDR: nxt_readData = {24'h000000, result_ff[3]};
      `SYS_OPT_ADDR: nxt_readData = {24'h000000, option_ff};
      `MODE_CFG_ADDR: nxt_readData = {31'h00000000, specialMode_ff};
      default: hit = 1'b0;
    endcase
  end

  // Read data and response are captured in the wait cycle and shown in the ack cycle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      avsReadData <= 32'h00000000;
      avsResponse <= 2'b00;
    end else begin
      avsReadData <= rdEn ? nxt_readData : 32'h00000000;
      avsResponse <= ((avsRead | avsWrite) & ~ack_ff & ~hit) ? 2'b10 : 2'b00;
    end
  end

endmodule

// *** rtl/sar_adc_sequencer_regs.vh ***
`ifndef SAR_ADC_SEQUENCER_REGS_VH
`define SAR_ADC_SEQUENCER_REGS_VH

// Register byte addresses on the bus: register index times four
`define ADC_CTRL_IDX 8'h30
`define ADC_RES1_IDX 8'h31
`define ADC_RES2_IDX 8'h32
`define ADC_RES3_IDX 8'h33
`define ADC_RES4_IDX 8'h34
`define SYS_OPT_IDX 8'h39
`define ADC_CTRL_ADDR 10'h0C0
`define ADC_RES1_ADDR 10'h0C4
`define ADC_RES2_ADDR 10'h0C8
`define ADC_RES3_ADDR 10'h0CC
`define ADC_RES4_ADDR 10'h0D0
`define SYS_OPT_ADDR 10'h0E4
`define MODE_CFG_ADDR 10'h100

// Control/status fields
`define CTRL_DONE_BIT 7
`define CTRL_SCAN_BIT 5
`define CTRL_MULTI_CHANNEL_SELECT_BIT 4
`define CTRL_WR_MASK 8'h3F

// Option fields
`define OPT_PWR_BIT 7
`define OPT_CONV_CLOCK_SELECT_BIT 6
`define OPT_PROT_MASK 8'h3F
`define OPT_RESET 8'h10

// Timing
`define CLK_PERIOD_NS 20
`define PROT_WINDOW_CYC 7'd64
`define SETTLE_TIME_US 100
`define SETTLE_CYC ((`SETTLE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define RC_DIV_HALF 8'h10
`define SAMPLE_STEPS 4'hC

`endif

// *** sim/sar_adc_sequencer_asserts.sv ***
`timescale 1ns/100ps
module sar_adc_sequencer_asserts (
  input wire mclk,
  input wire rst,
  input wire [9:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsReadData,
  input wire avsWaitRequest,
  input wire [1:0] avsResponse,
  input wire [7:0] dacCode,
  input wire sampleGate,
  input wire chargePumpEn,
  input wire biasEn,
  input wire rcOscEn,
  input wire nvmPumpClkSel,
  input wire convBusy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire isAck = (avsRead | avsWrite) & ~avsWaitRequest;
  wire mapped = (avsAddress >= 10'h0C0 && avsAddress <= 10'h0D0 && avsAddress[1:0] == 2'h0)
    || avsAddress == 10'h0E4 || avsAddress == 10'h100;
  ack_delay_a: assert property ($rose(avsRead | avsWrite) |-> avsWaitRequest ##1 !avsWaitRequest)
    else $error("ack not one cycle after request");
  rd_idle_a: assert property (!(avsRead && isAck) |-> avsReadData == 32'h0)
    else $error("read data outside ack");
  unmapped_err_a: assert property (isAck && !mapped |-> avsResponse == 2'h2 && avsReadData == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (isAck && mapped |-> avsResponse == 2'h0)
    else $error("mapped access refused");
  ctrl_bits_a: assert property (avsRead && isAck && avsAddress == 10'h0C0 |-> avsReadData[31:8] == 24'h0 && !avsReadData[6])
    else $error("control read bits wrong");
  pump_bias_a: assert property (biasEn == chargePumpEn)
    else $error("bias and pump differ");
  rc_select_a: assert property (rcOscEn == (chargePumpEn & nvmPumpClkSel))
    else $error("rc enable wrong");
  off_idle_a: assert property (!chargePumpEn |-> ##[0:2] !convBusy)
    else $error("busy while powered down");
  msb_first_a: assert property ($past(dacCode) == 8'h00 && dacCode != 8'h00 |-> dacCode == 8'h80)
    else $error("first trial not msb");
  dac_idle_a: assert property (!convBusy && !$past(convBusy) |-> dacCode == 8'h00)
    else $error("trial code while idle");
  cover property (avsWrite && isAck && avsAddress == 10'h0C0);
  cover property ($rose(sampleGate));
  cover property ($fell(convBusy));
endmodule

// *** sim/analog_front_model.sv ***
`timescale 1ns/100ps
module analog_front_model (
  input wire [7:0] dacCode,
  input wire [3:0] muxChannel,
  input wire sampleGate,
  input wire [7:0] shift,
  output wire compOut
);
  reg [7:0] held = 8'h00;
  function [7:0] level(input [3:0] ch, input [7:0] s);
    level = ch == 4'hC ? 8'hFF : ch == 4'hD ? 8'h00 : ch == 4'hE ? 8'h80 :
      ch[3] ? 8'h5A : 8'h13 + {4'h0, ch} * 8'h1D + s;
  endfunction
  // Sample and hold on the capacitor array
  always @(sampleGate or muxChannel or shift) begin
    if (sampleGate) begin
      held = level(muxChannel, shift);
    end
  end
  assign compOut = held >= dacCode;
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [9:0] avsAddress = 10'h000;
  reg avsRead = 1'b0;
  reg avsWrite = 1'b0;
  reg [31:0] avsWriteData = 32'h0;
  reg [3:0] avsByteEnable = 4'hF;
  reg [7:0] shift = 8'h00;
  wire [31:0] avsReadData;
  wire avsWaitRequest, compOut, sampleGate, chargePumpEn, biasEn, rcOscEn, nvmPumpClkSel, convBusy;
  wire [1:0] avsResponse;
  wire [7:0] dacCode;
  wire [3:0] muxChannel;
  integer err_total = 0;
  integer samples_checked = 0;
  reg [31:0] rd;
  reg [1:0] rsp;
  integer i;
  sar_adc_sequencer #(.SETTLE_CYCLES(4)) sar_adc_sequencer_i (.mclk(mclk), .rst(rst),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .avsResponse(avsResponse), .compOut(compOut), .dacCode(dacCode), .muxChannel(muxChannel),
    .sampleGate(sampleGate), .chargePumpEn(chargePumpEn), .biasEn(biasEn), .rcOscEn(rcOscEn),
    .nvmPumpClkSel(nvmPumpClkSel), .convBusy(convBusy));
  analog_front_model analog_front_model_i (.dacCode(dacCode), .muxChannel(muxChannel),
    .sampleGate(sampleGate), .shift(shift), .compOut(compOut));
  initial forever #10 mclk = ~mclk;
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    integer n;
    begin
      n = 0;
      @(posedge mclk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= ~wr;
      avsWriteData <= {24'h0, d};
      // Values read right after the edge are the ones the design sampled at it
      do begin @(posedge mclk); n = n + 1; end while (avsWaitRequest !== 1'b0 && n < 50);
      rd = avsReadData;
      rsp = avsResponse;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      if (n >= 50) err_total = err_total + 1;
    end
  endtask
  task rd_chk(input string name, input logic [9:0] a, input logic [31:0] exp);
    begin
      bus(1'b0, a, 8'h00);
      check(name, exp, rd);
    end
  endtask
  task wait_idle;
    integer n;
    begin
      n = 0;
      repeat (4) @(posedge mclk);
      while (convBusy !== 1'b0 && n < 3000) begin @(negedge mclk); n = n + 1; end
      if (n >= 3000) err_total = err_total + 1;
    end
  endtask
  task results(input logic [7:0] ctl);
    begin
      for (i = 0; i < 4; i = i + 1) begin
        bus(1'b0, 10'h0C4 + {6'h0, i[1:0], 2'h0}, 8'h00);
        check("result", {24'h0, analog_front_model_i.level(ctl[4] ? {ctl[3:2], i[1:0]} : ctl[3:0], shift)}, rd);
      end
    end
  endtask
  task t_convert(input logic [7:0] ctl);
    begin
      bus(1'b1, 10'h0C0, ctl);
      wait_idle;
      rd_chk("ctrl", 10'h0C0, {24'h0, 2'h2, ctl[5:0]});
      results(ctl);
      $display("t_convert %h done", ctl);
    end
  endtask
  task t_option;
    begin
      rd_chk("opt reset", 10'h0E4, 32'h10);
      rd_chk("ctrl reset", 10'h0C0, 32'h0);
      bus(1'b1, 10'h0E4, 8'hCA);
      rd_chk("opt first", 10'h0E4, 32'hCA);
      bus(1'b1, 10'h0E4, 8'hC5);
      rd_chk("opt locked", 10'h0E4, 32'hCA);
      bus(1'b1, 10'h100, 8'h01);
      bus(1'b1, 10'h0E4, 8'hC5);
      rd_chk("opt special", 10'h0E4, 32'hC5);
      bus(1'b1, 10'h100, 8'h00);
      check("pump", 32'hF, {28'h0, chargePumpEn, biasEn, rcOscEn, nvmPumpClkSel});
      $display("t_option done");
    end
  endtask
  task t_access;
    begin
      bus(1'b0, 10'h0F0, 8'h00);
      check("unmapped", 32'h2, {30'h0, rsp});
      bus(1'b1, 10'h0C4, 8'h55);
      rd_chk("result ro", 10'h0C4, 32'hFF);
      $display("t_access done");
    end
  endtask
  task t_power;
    begin
      bus(1'b1, 10'h0E4, 8'h00);
      bus(1'b1, 10'h0C0, 8'h03);
      repeat (40) @(posedge mclk);
      check("busy off", 32'h0, {31'h0, convBusy});
      rd_chk("ctrl off", 10'h0C0, 32'h03);
      bus(1'b1, 10'h0E4, 8'h80);
      $display("t_power done");
    end
  endtask
  task t_scan;
    integer n;
    begin
      bus(1'b1, 10'h0C0, 8'h21);
      repeat (30) @(posedge mclk);
      bus(1'b1, 10'h0C0, 8'h30);
      rd_chk("abort", 10'h0C0, 32'h30);
      n = 0;
      do begin bus(1'b0, 10'h0C0, 8'h00); n = n + 1; end while (rd[7] !== 1'b1 && n < 200);
      check("scan done", 32'hB0, rd);
      check("scan busy", 32'h1, {31'h0, convBusy});
      results(8'h30);
      shift <= 8'h08;
      repeat (400) @(posedge mclk);
      results(8'h30);
      bus(1'b1, 10'h0C0, 8'h00);
      wait_idle;
      shift <= 8'h00;
      $display("t_scan done");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    err_total = err_total + 1;
    final_report;
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_option;
    t_convert(8'h0C);
    bus(1'b1, 10'h0E4, 8'h80);
    t_access;
    t_convert(8'h0D);
    t_convert(8'h0E);
    t_convert(8'h03);
    t_convert(8'h17);
    t_power;
    t_convert(8'h10);
    t_scan;
    final_report;
  end
endmodule
bind sar_adc_sequencer sar_adc_sequencer_asserts sar_adc_sequencer_asserts_i (.mclk(mclk),
  .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .avsResponse(avsResponse),
  .dacCode(dacCode), .sampleGate(sampleGate), .chargePumpEn(chargePumpEn), .biasEn(biasEn),
  .rcOscEn(rcOscEn), .nvmPumpClkSel(nvmPumpClkSel), .convBusy(convBusy));
